// File: rtl/bus_cycle_engine.sv
// bus_cycle_engine: external bus cycles, status codes, stalls and prefetch.
// assumes the core holds a request until req_ready and splits odd words.
//
// Operation
// R1 - four-bit reason code, first pin least significant
// R2 - idle codes 0000, wait 0001, slave 0011
// R3 - interrupt acknowledge 0100, cascaded vector 0101
// R4 - interrupt return reads 0110, cascaded 0111
// R5 - data 1010, dsp 0010, modify read 1011, ea 1100
// R6 - sequential fetch 1000, first after purge 1001
// R7 - slave operand 1101, status 1110, id 1111
// R8 - unstalled cycle is T1 to T4, else idle
// R9 - T1: address out, strobe pulse, latch, direction
// R10 - T2: turn bus, timing, buffer, read/store strobes
// R11 - T3 holds all controls steady, repeatable
// R12 - read data captured at T4 start edge
// R13 - T4 releases strobes, buffer enable mid T4
// R14 - reason code changes at T4 start, ahead
// R15 - stalls allowed except slave cycles
// R16 - stall inputs sampled only at T2 end; the code samples the open-ended stall live at each later T3 end
// R17 - fixed stall code: active-low count, 0 to 3
// R18 - open-ended stall adds T3 while active
// R19 - prefetch even words when queue not full; the code needs two bytes free and fetches one byte at an odd flush_target
// R20 - first fetch after break is non-sequential
// R21 - interrupt cycles are single-byte reads
// R22 - A0 low selects low lane, enable selects high
`timescale 1ns/100ps
module bus_cycle_engine #(
    parameter int ADDR_W = 24,
    parameter int QUEUE_BYTES = bus_pkg::QUEUE_BYTES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // core requests
    input wire logic req_valid,
    input wire bus_pkg::req_class_t req_class,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic req_write,
    input wire logic req_word,
    input wire logic [15:0] req_wdata,
    output logic req_ready,
    output logic [15:0] read_data,
    output logic read_valid,
    output logic fetch_valid,
    // core state and prefetch queue
    input wire logic wait_instr_active,
    input wire logic slave_wait_active,
    input wire logic queue_take,
    input wire logic queue_flush,
    input wire logic [ADDR_W-1:0] flush_target,
    // bus pins
    output logic bus_clock_out,
    output logic [3:0] cycle_reason_code,
    input wire logic [15:0] muxed_addr_data_in,
    output logic [15:0] muxed_addr_data_out,
    output logic muxed_addr_data_oe,
    output logic [ADDR_W-17:0] upper_address,
    output logic addr_strobe_n,
    output logic latch_strobe,
    output logic direction_in_n,
    output logic high_byte_enable_n,
    output logic timing_state_out_n,
    output logic data_buffer_en_n,
    output logic read_strobe_n,
    output logic store_strobe_n,
    input wire logic [1:0] fixed_stall_code,
    input wire logic open_ended_stall_n
);

    // ==========================================================
    // state
    bus_pkg::tstate_t tstate_reg, tstate_next;
    logic phase_reg, bus_clk_reg;
    logic [3:0] code_reg, level_reg;
    logic [ADDR_W-1:0] fetch_pc_reg, nxt_addr_reg;
    logic nonseq_reg, req_ready_reg;
    logic nxt_valid_reg, nxt_write_reg, nxt_word_reg, nxt_fetch_reg, nxt_slave_reg;
    logic [15:0] nxt_wdata_reg, cur_wdata_reg, read_data_reg, out_reg;
    logic cur_write_reg, cur_fetch_reg, cur_odd_reg, cur_slave_reg, cur_stale_reg;
    logic read_valid_reg, fetch_valid_reg, oe_reg, ads_n_reg, latch_reg, dir_n_reg;
    logic hbyte_n_reg, tim_n_reg, buf_n_reg, rd_n_reg, wr_n_reg;
    logic [ADDR_W-17:0] upper_reg;

    stall_if st ();

    stall_counter u_stall (
        .ref_clk(ref_clk),
        .reset(reset),
        .st(st)
    );

    // ==========================================================
    // request decode and selection
    wire is_idle = (tstate_reg == bus_pkg::TS_IDLE);
    wire [3:0] req_code = bus_pkg::class_code(req_class); // see R3, R4, R5, R7
    wire req_int = (req_code[3:2] == 2'h1);
    wire req_slave = (req_code >= bus_pkg::CODE_SLAVE_OPERAND);
    wire req_can_write = (req_code == bus_pkg::CODE_DATA) ||
        (req_code == bus_pkg::CODE_DSP) || (req_code == bus_pkg::CODE_SLAVE_OPERAND);
    wire fetch_room = !queue_flush && (level_reg <= 4'(QUEUE_BYTES - 2)); // see R19
    wire have_work = req_valid || fetch_room;
    wire end_t3 = phase_reg && (tstate_reg == bus_pkg::TS_T3) && !st.extend;
    wire sel_point = end_t3 || (phase_reg && is_idle);
    wire [3:0] idle_code = slave_wait_active ? bus_pkg::CODE_SLAVE_WAIT :
        wait_instr_active ? bus_pkg::CODE_WAIT_INSTR : bus_pkg::CODE_IDLE; // see R2
    // requests win over prefetch; interrupt cycles forced to byte reads
    wire pick_write = req_valid && req_write && req_can_write && !req_int; // see R21
    wire pick_word = req_valid ? (req_word && !req_int && !req_addr[0]) : !fetch_pc_reg[0];
    wire [ADDR_W-1:0] pick_addr = req_valid ? req_addr : fetch_pc_reg;
    wire [3:0] pick_code = req_valid ? req_code :
        (nonseq_reg ? bus_pkg::CODE_NONSEQ_FETCH : bus_pkg::CODE_SEQ_FETCH); // see R6, R20
    wire pick_fetch = !req_valid;
    wire pick_slave = req_valid && req_slave;
    // from idle the cycle starts on the pick; after T4 on the latched pick
    wire nxt_go = nxt_valid_reg && !(queue_flush && nxt_fetch_reg);
    wire [ADDR_W-1:0] src_addr = is_idle ? pick_addr : nxt_addr_reg;
    wire src_write = is_idle ? pick_write : nxt_write_reg;
    wire src_word = is_idle ? pick_word : nxt_word_reg;
    wire src_fetch = is_idle ? pick_fetch : nxt_fetch_reg;
    wire src_slave = is_idle ? pick_slave : nxt_slave_reg;
    wire [15:0] src_wdata = is_idle ? req_wdata : nxt_wdata_reg;
    wire start_t1 = phase_reg && (tstate_next == bus_pkg::TS_T1) && !(tstate_reg == bus_pkg::TS_T1);

    // queue occupancy counts bytes reserved, so a fill in flight is counted
    wire reserve = sel_point && !req_valid && fetch_room;
    wire [3:0] reserve_amt = reserve ? (fetch_pc_reg[0] ? 4'h1 : 4'h2) : 4'h0; // see R19
    wire [3:0] take_amt = queue_take ? ((level_reg >= 4'h2) ? 4'h2 : level_reg) : 4'h0;
    wire [3:0] level_next = queue_flush ? 4'h0 : (level_reg - take_amt + reserve_amt);

    // stall counter hookup
    assign st.load = phase_reg && (tstate_reg == bus_pkg::TS_T2); // see R16
    assign st.step = phase_reg && (tstate_reg == bus_pkg::TS_T3);
    assign st.fixed_code_n = fixed_stall_code;
    assign st.open_n = open_ended_stall_n;
    assign st.no_stall = cur_slave_reg; // see R15

    // ==========================================================
    // t-state sequencing
    always_comb begin
        tstate_next = tstate_reg;
        case (tstate_reg)
            bus_pkg::TS_IDLE: if (have_work) tstate_next = bus_pkg::TS_T1; // see R8
            bus_pkg::TS_T1: tstate_next = bus_pkg::TS_T2;
            bus_pkg::TS_T2: tstate_next = bus_pkg::TS_T3; // see R11
            bus_pkg::TS_T3: if (!st.extend) tstate_next = bus_pkg::TS_T4; // see R18
            bus_pkg::TS_T4: tstate_next = nxt_go ? bus_pkg::TS_T1 : bus_pkg::TS_IDLE;
            default: tstate_next = bus_pkg::TS_IDLE;
        endcase
    end

    // bus clock is ref_clk halved; a t-state begins on its rising edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            phase_reg <= 1'b0;
            bus_clk_reg <= 1'b0;
            tstate_reg <= bus_pkg::TS_IDLE;
        end else begin
            phase_reg <= !phase_reg;
            bus_clk_reg <= phase_reg;
            if (phase_reg) tstate_reg <= tstate_next;
        end
    end

    // ==========================================================
    // selection, status code and prefetch bookkeeping
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            code_reg <= bus_pkg::CODE_RESET;
            req_ready_reg <= 1'b0;
            nxt_valid_reg <= 1'b0;
            nxt_fetch_reg <= 1'b0;
            level_reg <= 4'h0;
            fetch_pc_reg <= '0;
            nonseq_reg <= 1'b1;
        end else begin
            req_ready_reg <= sel_point && req_valid;
            if (sel_point) begin
                code_reg <= have_work ? pick_code : idle_code; // see R1, R14
                nxt_valid_reg <= have_work;
                nxt_fetch_reg <= pick_fetch;
            end else if (queue_flush && nxt_fetch_reg) begin
                nxt_valid_reg <= 1'b0; // a fetch not yet begun is dropped
            end
            level_reg <= level_next;
            if (queue_flush) begin
                fetch_pc_reg <= flush_target;
                nonseq_reg <= 1'b1; // see R20
            end else if (reserve) begin
                fetch_pc_reg <= fetch_pc_reg + ADDR_W'(reserve_amt);
                nonseq_reg <= 1'b0;
            end
        end
    end

    // latched pick for the cycle that follows a T4; no reset needed
    always_ff @(posedge ref_clk) begin
        if (sel_point) begin
            nxt_addr_reg <= pick_addr;
            nxt_write_reg <= pick_write;
            nxt_word_reg <= pick_word;
            nxt_slave_reg <= pick_slave;
            nxt_wdata_reg <= req_wdata;
        end
    end

    // ==========================================================
    // current cycle attributes and read capture
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cur_write_reg <= 1'b0;
            cur_fetch_reg <= 1'b0;
            cur_odd_reg <= 1'b0;
            cur_slave_reg <= 1'b0;
            cur_stale_reg <= 1'b0;
            cur_wdata_reg <= 16'h0000;
        end else if (start_t1) begin
            cur_write_reg <= src_write;
            cur_fetch_reg <= src_fetch;
            cur_odd_reg <= src_addr[0] && !src_word;
            cur_slave_reg <= src_slave;
            cur_wdata_reg <= src_word ? src_wdata : {2{src_wdata[7:0]}}; // see R22
            cur_stale_reg <= 1'b0;
        end else if (queue_flush) begin
            cur_stale_reg <= 1'b1; // fill from before a flush is discarded
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            read_data_reg <= 16'h0000;
            read_valid_reg <= 1'b0;
            fetch_valid_reg <= 1'b0;
        end else begin
            read_valid_reg <= 1'b0;
            fetch_valid_reg <= 1'b0;
            if (end_t3 && !cur_write_reg) begin
                // odd byte arrives on the high lane
                read_data_reg <= cur_odd_reg ? {8'h00, muxed_addr_data_in[15:8]} :
                    muxed_addr_data_in; // see R12
                read_valid_reg <= !cur_fetch_reg;
                fetch_valid_reg <= cur_fetch_reg && !cur_stale_reg && !queue_flush;
            end
        end
    end

    // ==========================================================
    // bus pin drivers, each step on a rising or falling bus clock edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_reg <= 16'h0000;
            oe_reg <= 1'b0;
            upper_reg <= '0;
            ads_n_reg <= bus_pkg::STROBE_N_RESET;
            latch_reg <= bus_pkg::LATCH_RESET;
            dir_n_reg <= bus_pkg::STROBE_N_RESET;
            hbyte_n_reg <= bus_pkg::STROBE_N_RESET;
            tim_n_reg <= bus_pkg::STROBE_N_RESET;
            buf_n_reg <= bus_pkg::STROBE_N_RESET;
            rd_n_reg <= bus_pkg::STROBE_N_RESET;
            wr_n_reg <= bus_pkg::STROBE_N_RESET;
        end else if (start_t1) begin
            out_reg <= src_addr[15:0]; // see R9
            upper_reg <= src_addr[ADDR_W-1:16];
            oe_reg <= 1'b1;
            ads_n_reg <= 1'b0;
            latch_reg <= 1'b1;
            dir_n_reg <= src_write;
            hbyte_n_reg <= !(src_word || src_addr[0]); // see R22
        end else if (!phase_reg && tstate_reg == bus_pkg::TS_T1) begin
            ads_n_reg <= 1'b1; // falling edge closes the external latch
            latch_reg <= 1'b0;
        end else if (phase_reg && tstate_reg == bus_pkg::TS_T1) begin
            out_reg <= cur_wdata_reg; // see R10
            oe_reg <= cur_write_reg;
            tim_n_reg <= 1'b0;
            buf_n_reg <= 1'b0;
            rd_n_reg <= cur_write_reg;
            wr_n_reg <= !cur_write_reg;
        end else if (end_t3) begin
            rd_n_reg <= 1'b1; // see R13
            wr_n_reg <= 1'b1;
            tim_n_reg <= 1'b1;
        end else if (!phase_reg && tstate_reg == bus_pkg::TS_T4) begin
            buf_n_reg <= 1'b1; // late release covers data hold
        end else if (phase_reg && tstate_reg == bus_pkg::TS_T4) begin
            latch_reg <= 1'b1;
            oe_reg <= 1'b0;
            dir_n_reg <= 1'b1;
            hbyte_n_reg <= 1'b1;
        end
    end

    // ==========================================================
    // outputs
    assign req_ready = req_ready_reg;
    assign read_data = read_data_reg;
    assign read_valid = read_valid_reg;
    assign fetch_valid = fetch_valid_reg;
    assign bus_clock_out = bus_clk_reg;
    assign cycle_reason_code = code_reg;
    assign muxed_addr_data_out = out_reg;
    assign muxed_addr_data_oe = oe_reg;
    assign upper_address = upper_reg;
    assign addr_strobe_n = ads_n_reg;
    assign latch_strobe = latch_reg;
    assign direction_in_n = dir_n_reg;
    assign high_byte_enable_n = hbyte_n_reg;
    assign timing_state_out_n = tim_n_reg;
    assign data_buffer_en_n = buf_n_reg;
    assign read_strobe_n = rd_n_reg;
    assign store_strobe_n = wr_n_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_plain_t3;
        (tstate_reg == bus_pkg::TS_T3) [*2] ##1 (tstate_reg == bus_pkg::TS_T4);
    endsequence

    sequence s_t4_release;
        !data_buffer_en_n && read_strobe_n && store_strobe_n && timing_state_out_n
            ##1 data_buffer_en_n;
    endsequence

    a_idle_code_zero: assert property (phase_reg && is_idle && !have_work && // see R2
        !wait_instr_active && !slave_wait_active |=> cycle_reason_code == bus_pkg::CODE_IDLE)
        else $error("idle code not zero");
    a_code_moves_t4: assert property ($changed(cycle_reason_code) |-> $past(sel_point)) // see R14
        else $error("status code changed outside selection edge");
    a_t1_address: assert property (start_t1 |=> !addr_strobe_n && muxed_addr_data_oe // see R9
        ##1 addr_strobe_n && !latch_strobe)
        else $error("address phase wrong");
    a_t2_strobes: assert property (phase_reg && tstate_reg == bus_pkg::TS_T1 |=> // see R10
        !timing_state_out_n && !data_buffer_en_n && (read_strobe_n != store_strobe_n))
        else $error("T2 strobes not asserted");
    a_no_wait_len: assert property (st.load && fixed_stall_code == 2'h3 && // see R8
        open_ended_stall_n |=> s_plain_t3)
        else $error("unstalled cycle not one T3");
    a_slave_no_stall: assert property (st.load && cur_slave_reg |=> s_plain_t3) // see R15
        else $error("slave cycle stalled");
    a_fixed_three: assert property (st.load && fixed_stall_code == 2'h0 && // see R17
        !cur_slave_reg |=> (tstate_reg == bus_pkg::TS_T3) [*8])
        else $error("three fixed waits not inserted");
    a_t3_steady: assert property (st.step && st.extend |=> // see R11
        (tstate_reg == bus_pkg::TS_T3 && $stable(read_strobe_n) &&
        $stable(timing_state_out_n) && $stable(data_buffer_en_n)) [*2])
        else $error("controls moved during wait");
    a_t4_release: assert property (end_t3 |=> s_t4_release) // see R13
        else $error("T4 release order wrong");
    a_read_capture: assert property (end_t3 && !cur_write_reg && !cur_fetch_reg && // see R12
        !cur_odd_reg |=> read_valid && read_data == $past(muxed_addr_data_in))
        else $error("read data not captured at T4");
    a_seq_fetch_even: assert property (tstate_reg == bus_pkg::TS_T1 && !phase_reg && // see R19
        cycle_reason_code == bus_pkg::CODE_SEQ_FETCH |->
        !muxed_addr_data_out[0] && !high_byte_enable_n)
        else $error("sequential fetch not even word");
    a_int_byte_read: assert property (tstate_reg == bus_pkg::TS_T1 && !phase_reg && // see R21
        cycle_reason_code[3:2] == 2'h1 |->
        !direction_in_n && (muxed_addr_data_out[0] == !high_byte_enable_n))
        else $error("interrupt cycle not byte read");

endmodule : bus_cycle_engine

// File: rtl/bus_pkg.sv
// bus_pkg: constants, codes and types of the external bus cycle engine.
// assumes a single 50 MHz reference clock; the bus clock is derived from it.
package bus_pkg;

    // ==========================================================
    // timing
    localparam int REF_CLK_PERIOD_NS = 20;
    localparam int REF_CYCLES_PER_TSTATE = 2; // one bus clock period per t-state
    localparam int QUEUE_BYTES = 8;

    // ==========================================================
    // reset values of the bus pins
    localparam logic STROBE_N_RESET = 1'b1;
    localparam logic LATCH_RESET = 1'b1;
    localparam logic [3:0] CODE_RESET = 4'h0;

    // ==========================================================
    // cycle-reason codes
    localparam logic [3:0] CODE_IDLE = 4'h0;
    localparam logic [3:0] CODE_WAIT_INSTR = 4'h1;
    localparam logic [3:0] CODE_DSP = 4'h2;
    localparam logic [3:0] CODE_SLAVE_WAIT = 4'h3;
    localparam logic [3:0] CODE_INTA_MASTER = 4'h4;
    localparam logic [3:0] CODE_INTA_CASC = 4'h5;
    localparam logic [3:0] CODE_EOI_MASTER = 4'h6;
    localparam logic [3:0] CODE_EOI_CASC = 4'h7;
    localparam logic [3:0] CODE_SEQ_FETCH = 4'h8;
    localparam logic [3:0] CODE_NONSEQ_FETCH = 4'h9;
    localparam logic [3:0] CODE_DATA = 4'hA;
    localparam logic [3:0] CODE_MOD_READ = 4'hB;
    localparam logic [3:0] CODE_EA_READ = 4'hC;
    localparam logic [3:0] CODE_SLAVE_OPERAND = 4'hD;
    localparam logic [3:0] CODE_SLAVE_STATUS = 4'hE;
    localparam logic [3:0] CODE_SLAVE_ID = 4'hF;

    // ==========================================================
    // request classes from the core
    typedef enum logic [3:0] {
        CLS_DATA = 4'h0, CLS_MOD_READ = 4'h1, CLS_EA_READ = 4'h2, CLS_DSP = 4'h3,
        CLS_INTA_MASTER = 4'h4, CLS_INTA_CASC = 4'h5, CLS_EOI_MASTER = 4'h6,
        CLS_EOI_CASC = 4'h7, CLS_SLAVE_OPERAND = 4'h8, CLS_SLAVE_STATUS = 4'h9,
        CLS_SLAVE_ID = 4'hA
    } req_class_t;

    // bus t-states, one-hot
    typedef enum logic [4:0] {
        TS_IDLE = 5'h01, TS_T1 = 5'h02, TS_T2 = 5'h04, TS_T3 = 5'h08, TS_T4 = 5'h10
    } tstate_t;

    // class to shown code; unused class values fall back to plain data
    function automatic logic [3:0] class_code(input req_class_t cls);
        case (cls)
            CLS_MOD_READ: return CODE_MOD_READ;
            CLS_EA_READ: return CODE_EA_READ;
            CLS_DSP: return CODE_DSP;
            CLS_INTA_MASTER: return CODE_INTA_MASTER;
            CLS_INTA_CASC: return CODE_INTA_CASC;
            CLS_EOI_MASTER: return CODE_EOI_MASTER;
            CLS_EOI_CASC: return CODE_EOI_CASC;
            CLS_SLAVE_OPERAND: return CODE_SLAVE_OPERAND;
            CLS_SLAVE_STATUS: return CODE_SLAVE_STATUS;
            CLS_SLAVE_ID: return CODE_SLAVE_ID;
            default: return CODE_DATA;
        endcase
    endfunction : class_code

endpackage : bus_pkg

// File: rtl/stall_if.sv
// stall_if: wait-state control between the cycle engine and its stall counter.
// assumes both ends sit in the ref_clk domain.
`timescale 1ns/100ps
interface stall_if;
    logic load;
    logic step;
    logic [1:0] fixed_code_n;
    logic open_n;
    logic no_stall;
    logic extend;

    modport ctl (output load, step, fixed_code_n, open_n, no_stall, input extend);
    modport cnt (input load, step, fixed_code_n, open_n, no_stall, output extend);
endinterface : stall_if

// File: rtl/stall_counter.sv
// stall_counter: decides at each T3 end whether another T3 follows.
// assumes load pulses at the T2 end edge and step at each T3 end edge.
`timescale 1ns/100ps
module stall_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // control from the cycle engine
    stall_if.cnt st
);

    logic [1:0] fixed_left_reg;
    logic open_t2_reg;
    logic first_reg;

    // ==========================================================
    // fixed count first, then the open-ended input each T3
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fixed_left_reg <= 2'h0;
            open_t2_reg <= 1'b0;
            first_reg <= 1'b0;
        end else if (st.load) begin
            fixed_left_reg <= st.no_stall ? 2'h0 : ~st.fixed_code_n; // see R16, R17
            open_t2_reg <= !st.no_stall && !st.open_n; // see R15
            first_reg <= 1'b1;
        end else if (st.step) begin
            if (fixed_left_reg != 2'h0) begin
                fixed_left_reg <= fixed_left_reg - 2'h1;
            end
            first_reg <= 1'b0;
        end
    end

    // the base T3 uses the T2 sample; later waits sample the pin live
    assign st.extend = (fixed_left_reg != 2'h0) ||
        (first_reg ? open_t2_reg : !st.open_n); // see R18

endmodule : stall_counter

// File: test/mem_model.sv
// mem_model: read data made from the latched address behind the multiplexed bus, with stall inputs.
// assumes the engine's pin timing; stall settings come from the bench.
`timescale 1ns/100ps
module mem_model (
    // bus pins
    input wire logic bus_clock_out,
    input wire logic latch_strobe,
    input wire logic read_strobe_n,
    input wire logic store_strobe_n,
    input wire logic [15:0] muxed_addr_data_out,
    output logic [15:0] muxed_addr_data_in,
    output logic [1:0] fixed_stall_code,
    output logic open_ended_stall_n,
    // stall settings
    input wire logic [1:0] fixed_cfg_n,
    input wire logic [3:0] open_cfg
);
    logic [15:0] addr_reg = 16'h0000;
    logic [3:0] open_reg = 4'h0;
    logic armed = 1'b0;
    // =====================================
    // address taken as the latch closes
    always @(negedge latch_strobe) begin
        addr_reg = muxed_addr_data_out;
        open_reg = open_cfg;
    end
    // one open stall sample used up per strobed t-state end; armed mid-state, free of races
    always @(negedge bus_clock_out) armed = !(read_strobe_n && store_strobe_n);
    always @(posedge bus_clock_out) begin
        if (armed && open_reg != 4'h0) open_reg = open_reg - 4'h1;
    end
    // released bus shows the inverse, so a late capture is caught
    assign muxed_addr_data_in = read_strobe_n ? addr_reg ^ 16'h5A3C : addr_reg ^ 16'hA5C3;
    assign fixed_stall_code = fixed_cfg_n;
    assign open_ended_stall_n = (open_reg == 4'h0);
endmodule : mem_model

// File: test/bus_cycle_engine_tb_top.sv
// bus_cycle_engine_tb_top: directed checks of codes, strobes and stalls.
// assumes rtl/ and mem_model; queue never drained, so prefetch stops.
`timescale 1ns/100ps
module bus_cycle_engine_tb_top;
    logic ref_clk, reset, req_valid, req_write, req_word, req_ready, read_valid;
    logic wia, swa, bclk, oe, ads_n, latch, dir_n, hb_n, tim_n, buf_n, rd_n, wr_n, opn_n, fv;
    bus_pkg::req_class_t req_class;
    logic [23:0] req_addr;
    logic [15:0] req_wdata, read_data, ad_in, ad_out;
    logic [7:0] upper;
    logic [3:0] code, open_cfg;
    logic [1:0] fix_code, fix_cfg;
    int mismatches = 0, n_tests = 0, len, i;
    logic [3:0] codes [11] = '{4'hA, 4'hB, 4'hC, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
    bus_cycle_engine u_bus_cycle_engine (.ref_clk(ref_clk), .reset(reset),
        .req_valid(req_valid), .req_class(req_class), .req_addr(req_addr),
        .req_write(req_write), .req_word(req_word), .req_wdata(req_wdata),
        .req_ready(req_ready), .read_data(read_data), .read_valid(read_valid),
        .fetch_valid(fv), .wait_instr_active(wia), .slave_wait_active(swa), .queue_take(1'b0),
        .queue_flush(1'b0), .flush_target(24'h000000), .bus_clock_out(bclk),
        .cycle_reason_code(code), .muxed_addr_data_in(ad_in), .muxed_addr_data_out(ad_out),
        .muxed_addr_data_oe(oe), .upper_address(upper), .addr_strobe_n(ads_n),
        .latch_strobe(latch), .direction_in_n(dir_n), .high_byte_enable_n(hb_n),
        .timing_state_out_n(tim_n), .data_buffer_en_n(buf_n), .read_strobe_n(rd_n),
        .store_strobe_n(wr_n), .fixed_stall_code(fix_code), .open_ended_stall_n(opn_n));
    mem_model u_mem_model (.bus_clock_out(bclk), .latch_strobe(latch), .read_strobe_n(rd_n),
        .store_strobe_n(wr_n), .muxed_addr_data_out(ad_out), .muxed_addr_data_in(ad_in),
        .fixed_stall_code(fix_code), .open_ended_stall_n(opn_n), .fixed_cfg_n(fix_cfg),
        .open_cfg(open_cfg));
    // =====================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    // bounded wait: sel 0 for the request taken, 1 for an address strobe
    task automatic await(input int sel);
        int k;
        for (k = 0; k < 80 && !(sel == 0 ? req_ready === 1'b1 : ads_n === 1'b0); k++)
            @(negedge ref_clk);
        if (k == 80) begin
            mismatches++;
            end_sim();
        end
    endtask : await
    // =====================================
    // scenarios
    task automatic t_prefetch;
        await(1);
        chk({code, hb_n, ad_out}, {4'h9, 1'b0, 16'h0000});
        repeat (6) @(negedge ref_clk);
        chk({fv, read_data}, {1'b1, 16'hA5C3});
        await(1);
        chk({code, hb_n, ad_out}, {4'h8, 1'b0, 16'h0002});
        repeat (60) @(negedge ref_clk);
    endtask : t_prefetch
    task automatic t_idle(input logic w, input logic s, input logic [3:0] ec);
        {wia, swa} = {w, s};
        repeat (5) @(negedge ref_clk);
        chk(code, ec);
    endtask : t_idle
    task automatic t_read(input bus_pkg::req_class_t c, input logic [23:0] a,
            input logic [1:0] fx, input logic [3:0] op, input logic [3:0] ec, input int w,
            input logic eh, input logic dc);
        logic [15:0] d;
        d = a[15:0] ^ 16'hA5C3;
        req_class = c;
        {req_addr, fix_cfg, open_cfg} = {a, fx, op};
        {req_valid, req_write, req_word} = 3'b101;
        await(0);
        req_valid = 1'b0;
        chk({code, ads_n, dir_n, hb_n, upper, ad_out}, {ec, 2'b00, eh, a});
        repeat (2) @(negedge ref_clk);
        chk({rd_n, tim_n, buf_n, oe}, 4'h0);
        for (len = 2; len < 40 && read_valid !== 1'b1; len++) @(negedge ref_clk);
        chk(len, 6 + 2 * w);
        if (dc) chk(read_data, a[0] ? {8'h00, d[15:8]} : d);
        chk({rd_n, tim_n, buf_n}, 3'b110);
    endtask : t_read
    task automatic t_write;
        req_class = bus_pkg::CLS_DATA;
        {req_addr, req_wdata, fix_cfg, open_cfg} = {24'h00C0DE, 16'hBEEF, 6'h30};
        {req_valid, req_write, req_word} = 3'b111;
        await(0);
        req_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({wr_n, rd_n, oe, tim_n, buf_n, dir_n, ad_out}, {6'h19, 16'hBEEF});
        repeat (4) @(negedge ref_clk);
        chk({wr_n, tim_n, buf_n, ad_out}, {3'b110, 16'hBEEF});
        @(negedge ref_clk);
        chk({buf_n, ad_out}, {1'b1, 16'hBEEF});
    endtask : t_write
    // =====================================
    // clock and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        {reset, req_valid, req_write, req_word, wia, swa} = 6'h20;
        req_class = bus_pkg::CLS_DATA;
        {req_addr, req_wdata, fix_cfg, open_cfg} = {24'h0, 16'h0, 6'h30};
        repeat (3) @(negedge ref_clk);
        reset = 1'b0;
        t_prefetch();
        t_idle(1'b1, 1'b0, 4'h1);
        t_idle(1'b1, 1'b1, 4'h3);
        t_idle(1'b0, 1'b0, 4'h0);
        for (i = 0; i < 11; i++)
            t_read(bus_pkg::req_class_t'(i), 24'h12A0B0 + 24'(2 * i), ~2'(i), 4'h0,
                codes[i], i > 7 ? 0 : i % 4, i > 3 && i < 8, !(i > 3 && i < 8));
        t_read(bus_pkg::CLS_DATA, 24'h004000, 2'h3, 4'h1, 4'hA, 1, 1'b0, 1'b1);
        t_read(bus_pkg::CLS_DATA, 24'h004100, 2'h3, 4'h4, 4'hA, 3, 1'b0, 1'b1);
        t_read(bus_pkg::CLS_DATA, 24'h000135, 2'h3, 4'h0, 4'hA, 0, 1'b0, 1'b1);
        t_write();
        end_sim();
    end
endmodule : bus_cycle_engine_tb_top
